/* File: common/stc_cfg.svh */
// Register map, field positions, reset values and timing counts of the self-test controller
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

`define STC_OFS_CTRL 28'hFFFE100
`define STC_OFS_INTV 28'hFFFE104
`define STC_OFS_DIV 28'hFFFE108
`define STC_OFS_TMO 28'hFFFE10C
`define STC_OFS_STAT 28'hFFFE110
`define STC_OFS_MASK 28'hFFFE114
`define STC_OFS_FAIL 28'hFFFE118
`define STC_OFS_EXC 28'hFFFE11C
`define STC_OFS_CUR 28'hFFFE120

`define STC_CTRL_EN 0
`define STC_CTRL_RESTART 1
`define STC_ST_DONE 0
`define STC_ST_FAIL 1
`define STC_ST_TMO 2
`define STC_ST_BUSY 3
`define STC_EXC_STC_RST 5

`define STC_DIV_RST 3'h0
`define STC_INTV_RST 5'h00
`define STC_TMO_RST 32'h0010_0000
`define STC_MASK_RST 3'h0

`define STC_INTV_CYC 11'd1365
`define STC_NUM_INTV 5'd26
`define STC_RST_CYC 4'd8
`define STC_SEED 32'hACE1_5A3C
`define STC_POLY 32'h8020_0003

`endif

/* File: common/stc_link_if.sv */
// Signals between the controller, the test engine and the clock divider
`timescale 1ns/10ps
interface stc_link_if (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce
);
  logic [2:0] ratio;
  logic tick;
  logic tick_dly;
  logic run;
  logic [4:0] intv;
  logic done;
  logic fail;
  logic [31:0] pattern;

  modport ctl (input clk_sys, rst_n, ce, tick, tick_dly, done, fail, pattern,
    output ratio, run, intv);
  modport eng (input clk_sys, rst_n, ce, tick, run, intv, output done, fail, pattern);
  modport div (input clk_sys, rst_n, ce, ratio, output tick, tick_dly);
endinterface : stc_link_if

/* File: common/stc_pkg.sv */
// Types of the self-test controller
package stc_pkg;

  typedef enum logic [2:0] {
    STC_IDLE = 3'b001,
    STC_RUN = 3'b010,
    STC_RST = 3'b100
  } stc_state_t;

  typedef struct packed {
    stc_state_t state;
    logic [2:0] div;
    logic [4:0] intv_sel;
    logic [31:0] tmo;
    logic [31:0] tmo_cnt;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [4:0] fail_intv;
    logic [4:0] cur_intv;
    logic [4:0] done_cnt;
    logic exc_stc;
    logic [3:0] rst_cnt;
    logic isolate;
    logic cpu_rst;
    logic irq;
    logic wait_q;
    logic [31:0] rdata;
  } stc_top_st_t;

  typedef struct packed {
    logic [10:0] cnt;
    logic [31:0] lfsr;
    logic [31:0] misr0;
    logic [31:0] misr1;
    logic done;
    logic fail;
  } stc_eng_st_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
    logic en_d1;
    logic en_d2;
  } stc_div_st_t;

endpackage : stc_pkg

/* File: core/stc_clk_div.sv */
// Self-test clock enable divider with a two-cycle delayed copy
`timescale 1ns/10ps
module stc_clk_div
  import stc_pkg::*;
(
  stc_link_if.div lk
);
  stc_div_st_t q;
  stc_div_st_t d;

  // Ratio is field plus one, 1 to 8
  always_comb begin
    d = q;
    if (q.cnt >= lk.ratio) begin
      d.cnt = 3'h0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 3'h1;
      d.tick = 1'b0;
    end
    d.en_d1 = q.tick;
    d.en_d2 = q.en_d1;
  end

  always_ff @(posedge lk.clk_sys) begin
    if (!lk.rst_n) begin
      q <= '0;
    end else if (lk.ce) begin
      q <= d;
    end
  end

  assign lk.tick = q.tick;
  assign lk.tick_dly = q.en_d2;
endmodule : stc_clk_div

/* File: core/stc_engine.sv */
// Deterministic pattern generator and dual response compactor, one interval at a time
`timescale 1ns/10ps
`include "stc_cfg.svh"
module stc_engine
  import stc_pkg::*;
(
  stc_link_if.eng lk,
  // Core responses
  input wire logic [31:0] resp0,
  input wire logic [31:0] resp1
);
  stc_eng_st_t q;
  stc_eng_st_t d;
  logic [31:0] nxt0;
  logic [31:0] nxt1;

  // Shift with polynomial feedback, input folded in
  function automatic logic [31:0] step(input logic [31:0] s, input logic [31:0] din);
    logic [31:0] r;
    r = {s[30:0], 1'b0};
    if (s[31]) begin
      r = r ^ `STC_POLY;
    end
    return r ^ din;
  endfunction : step

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.fail = 1'b0;
    nxt0 = step(q.misr0, resp0);
    nxt1 = step(q.misr1, resp1);
    if (!lk.run) begin
      d.cnt = 11'd0;
      d.lfsr = `STC_SEED;
      d.misr0 = '0;
      d.misr1 = '0;
    end else if (lk.tick) begin
      if (q.cnt == 11'd0) begin
        // Each interval starts from its own seed, so intervals stand alone
        d.lfsr = step(`STC_SEED ^ {27'h0, lk.intv}, 32'h0);
      end else begin
        d.lfsr = step(q.lfsr, 32'h0);
      end
      if (q.cnt == `STC_INTV_CYC - 11'd1) begin
        d.cnt = 11'd0;
        d.done = (nxt0 == nxt1);
        d.fail = (nxt0 != nxt1);
        d.misr0 = '0;
        d.misr1 = '0;
      end else begin
        d.cnt = q.cnt + 11'd1;
        d.misr0 = nxt0;
        d.misr1 = nxt1;
      end
    end
  end

  always_ff @(posedge lk.clk_sys) begin
    if (!lk.rst_n) begin
      q <= '0;
      // Pattern rests at the seed, so it does not jump when reset ends
      q.lfsr <= `STC_SEED;
    end else if (lk.ce) begin
      q <= d;
    end
  end

  assign lk.done = q.done;
  assign lk.fail = q.fail;
  assign lk.pattern = q.lfsr;
endmodule : stc_engine

/* File: core/stc_top.sv */
// Processor logic self-test controller with Avalon-MM register slave
// Contract
// - Test both cores with a deterministic pattern generator and response checker.
// - Split the test into independent intervals; run all or a selected number.
// - At run start, resume after the last interval or restart from the first.
// - Isolate the core under test from the system while the run is active.
// - Record the number of the failing interval for software.
// - Timeout counter loaded from software period guards every run.
// - Controller ends the run with processor reset; handler reads the status.
// - Divide ratio comes from the divider register at its fixed address.
// - Each interval lasts 1365 self-test clock cycles.
// - Processor clock and delayed copy divided by the same ratio, 1 to 8.
// - Reset from the controller sets bit 5 of exception status.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`include "stc_cfg.svh"
module stc_top
  import stc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [27:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Cores under test
  input wire logic [31:0] core0_resp,
  input wire logic [31:0] core1_resp,
  output logic [31:0] test_pattern,
  output logic core_isolate,
  output logic proc_clk_en,
  output logic delayed_proc_clk_en,
  output logic cpu_reset,
  // Interrupt
  output logic irq
);
  stc_top_st_t q;
  stc_top_st_t d;
  logic acc;
  logic wr_now;
  logic start_req;
  logic [2:0] clr;
  logic [2:0] ev;
  logic [4:0] nxt_intv;
  logic [4:0] nxt_cnt;
  logic [31:0] mw;

  stc_link_if lk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce)
  );

  stc_clk_div u_div (
    .lk(lk.div)
  );

  stc_engine u_eng (
    .lk(lk.eng),
    .resp0(core0_resp),
    .resp1(core1_resp)
  );

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
      input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Wrapping interval increment
  function automatic logic [4:0] inc_intv(input logic [4:0] v);
    if (v >= `STC_NUM_INTV - 5'd1) begin
      return 5'h00;
    end
    return v + 5'h01;
  endfunction : inc_intv

  function automatic logic [31:0] rd_mux(input logic [27:0] a, input stc_top_st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `STC_OFS_CTRL: r = 32'h0000_0000;
      `STC_OFS_INTV: r = {27'h0, s.intv_sel};
      `STC_OFS_DIV: r = {29'h0, s.div};
      `STC_OFS_TMO: r = s.tmo;
      `STC_OFS_STAT: r = {28'h0, s.state != STC_IDLE, s.stat};
      `STC_OFS_MASK: r = {29'h0, s.mask};
      `STC_OFS_FAIL: r = {27'h0, s.fail_intv};
      `STC_OFS_EXC: r = {26'h0, s.exc_stc, 5'h00};
      `STC_OFS_CUR: r = {27'h0, s.cur_intv};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  always_comb begin
    d = q;
    acc = read || write;
    wr_now = write && !q.wait_q;
    start_req = 1'b0;
    clr = 3'h0;
    ev = 3'h0;
    nxt_intv = inc_intv(q.cur_intv);
    nxt_cnt = q.done_cnt + 5'h01;
    mw = 32'h0000_0000;

    // One wait cycle, then the answer; write acts at the edge that ends it
    if (q.wait_q && acc) begin
      d.wait_q = 1'b0;
      if (read) begin
        d.rdata = rd_mux(address, q);
      end
    end else if (!q.wait_q) begin
      d.wait_q = 1'b1;
    end

    if (wr_now) begin
      case (address)
        `STC_OFS_CTRL: begin
          if (byteenable[0] && writedata[`STC_CTRL_EN]) begin
            start_req = 1'b1;
          end
        end
        `STC_OFS_INTV: begin
          if (q.state == STC_IDLE) begin
            mw = merge({27'h0, q.intv_sel}, writedata, byteenable);
            d.intv_sel = mw[4:0];
          end
        end
        `STC_OFS_DIV: begin
          if (q.state == STC_IDLE) begin
            mw = merge({29'h0, q.div}, writedata, byteenable);
            d.div = mw[2:0];
          end
        end
        `STC_OFS_TMO: begin
          if (q.state == STC_IDLE) begin
            d.tmo = merge(q.tmo, writedata, byteenable);
          end
        end
        `STC_OFS_STAT: begin
          if (byteenable[0]) begin
            clr = writedata[2:0];
          end
        end
        `STC_OFS_MASK: begin
          mw = merge({29'h0, q.mask}, writedata, byteenable);
          d.mask = mw[2:0];
        end
        `STC_OFS_EXC: begin
          if (byteenable[0] && writedata[`STC_EXC_STC_RST]) begin
            d.exc_stc = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (q.state)
      STC_IDLE: begin
        if (start_req) begin
          if (writedata[`STC_CTRL_RESTART]) begin
            d.cur_intv = 5'h00;
          end else begin
            d.cur_intv = q.cur_intv;
          end
          d.done_cnt = 5'h00;
          d.tmo_cnt = q.tmo;
          d.isolate = 1'b1;
          d.state = STC_RUN;
        end
      end
      STC_RUN: begin
        d.tmo_cnt = q.tmo_cnt - 32'h1;
        if (q.tmo_cnt == 32'h0) begin
          ev[`STC_ST_TMO] = 1'b1;
          d.state = STC_RST;
        end else if (lk.fail) begin
          d.fail_intv = q.cur_intv;
          ev[`STC_ST_FAIL] = 1'b1;
          d.state = STC_RST;
        end else if (lk.done) begin
          d.cur_intv = nxt_intv;
          d.done_cnt = nxt_cnt;
          // Zero selection runs every remaining interval
          if ((nxt_cnt == q.intv_sel) || (nxt_intv == 5'h00)) begin
            ev[`STC_ST_DONE] = 1'b1;
            d.state = STC_RST;
          end
        end
        if (d.state == STC_RST) begin
          d.cpu_rst = 1'b1;
          d.exc_stc = 1'b1;
          d.rst_cnt = 4'h0;
        end
      end
      STC_RST: begin
        d.exc_stc = 1'b1;
        if (q.rst_cnt == `STC_RST_CYC - 4'h1) begin
          d.cpu_rst = 1'b0;
          d.isolate = 1'b0;
          d.state = STC_IDLE;
        end else begin
          d.rst_cnt = q.rst_cnt + 4'h1;
        end
      end
      default: begin
        d.state = STC_IDLE;
        d.cpu_rst = 1'b0;
        d.isolate = 1'b0;
      end
    endcase

    // Hardware set wins over a software clear in the same cycle
    d.stat = (q.stat & ~clr) | ev;
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= STC_IDLE;
      q.div <= `STC_DIV_RST;
      q.intv_sel <= `STC_INTV_RST;
      q.tmo <= `STC_TMO_RST;
      q.mask <= `STC_MASK_RST;
      q.wait_q <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign lk.ratio = q.div;
  assign lk.run = (q.state == STC_RUN);
  // Engine seeds from the interval about to run, not the one just ended
  assign lk.intv = d.cur_intv;

  assign readdata = q.rdata;
  assign waitrequest = q.wait_q;
  assign test_pattern = lk.pattern;
  assign core_isolate = q.isolate;
  assign proc_clk_en = lk.tick;
  assign delayed_proc_clk_en = lk.tick_dly;
  assign cpu_reset = q.cpu_rst;
  assign irq = q.irq;
endmodule : stc_top

/* File: verification/stc_core_model.sv */
// Behavioural pair of lockstep cores answering test patterns
`timescale 1ns/10ps
module stc_core_model (
  // Clock
  input wire logic clk_sys,
  // Stimulus and fault injection
  input wire logic [31:0] test_pattern,
  input wire logic fault,
  // Responses
  output logic [31:0] core0_resp,
  output logic [31:0] core1_resp
);
  // Both cores see the same pattern; fault upsets one bit of core 1
  always @(posedge clk_sys) begin
    core0_resp <= {test_pattern[15:0], test_pattern[31:16]} ^ 32'h5A5A_0F0F;
    core1_resp <= {test_pattern[15:0], test_pattern[31:16]} ^ 32'h5A5A_0F0F ^ {31'h0, fault};
  end
endmodule : stc_core_model

/* File: verification/stc_top_sva.sv */
// Port-level checks of the self-test controller
`timescale 1ns/10ps
`include "stc_cfg.svh"
module stc_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Register bus
  input wire logic [27:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // Core side
  input wire logic [31:0] test_pattern,
  input wire logic core_isolate,
  input wire logic proc_clk_en,
  input wire logic delayed_proc_clk_en,
  input wire logic cpu_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_bus_answer: assert property (ce && (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");
  chk_wait_pulse: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low too long");
  chk_rst_len: assert property ($rose(cpu_reset) |-> cpu_reset[*8] ##1 !cpu_reset)
    else $error("processor reset length wrong");
  chk_iso_rst: assert property (cpu_reset |-> core_isolate)
    else $error("core released during reset");
  chk_iso_drop: assert property ($fell(cpu_reset) |-> ##[0:1] !core_isolate)
    else $error("isolation kept after reset");
  chk_start_iso: assert property (write && !waitrequest && address == `STC_OFS_CTRL &&
    writedata[0] && byteenable[0] && !core_isolate |-> ##[1:2] core_isolate)
    else $error("start did not isolate core");
  chk_div_copy: assert property (delayed_proc_clk_en == $past(proc_clk_en, 2))
    else $error("delayed clock enable not two cycles late");
  chk_pat_run: assert property ($changed(test_pattern) |-> core_isolate || $past(core_isolate))
    else $error("pattern moved outside a run");
endmodule : stc_top_chk

/* File: verification/tb.sv */
// Self-checking bench of the self-test controller
`timescale 1ns/10ps
`include "stc_cfg.svh"
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [27:0] address = 28'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic fault = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, test_pattern, core0_resp, core1_resp, rd;
  logic waitrequest, core_isolate, proc_clk_en, delayed_proc_clk_en, cpu_reset, irq;
  int num_errors = 0;
  int checks = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;

  stc_top stc_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .core0_resp(core0_resp),
    .core1_resp(core1_resp), .test_pattern(test_pattern), .core_isolate(core_isolate),
    .proc_clk_en(proc_clk_en), .delayed_proc_clk_en(delayed_proc_clk_en),
    .cpu_reset(cpu_reset), .irq(irq));
  stc_core_model stc_core_model_i (.clk_sys(clk_sys), .test_pattern(test_pattern),
    .fault(fault), .core0_resp(core0_resp), .core1_resp(core1_resp));

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One bus access, held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic wr, input logic [27:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk_sys);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) begin
      num_errors++;
      conclude();
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc

  task automatic rdchk(input logic [27:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Bounded wait for the closing processor reset
  task automatic wait_end;
    n = 0;
    while (cpu_reset !== 1'b1 && n < 4000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 4000) begin
      num_errors++;
      conclude();
    end
    repeat (12) @(negedge clk_sys);
  endtask : wait_end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(`STC_OFS_TMO, 32'h0010_0000);
    rdchk(`STC_OFS_DIV, 32'h0);
    rdchk(28'h0000010, 32'h0);
    acc(1'b1, `STC_OFS_DIV, 32'h1);
    rdchk(`STC_OFS_DIV, 32'h1);
    n = 0;
    repeat (16) begin
      @(negedge clk_sys);
      n += proc_clk_en;
    end
    chk(32'(n), 32'h8);
    acc(1'b1, `STC_OFS_DIV, 32'h0);
    acc(1'b1, `STC_OFS_INTV, 32'h1);
    acc(1'b1, `STC_OFS_TMO, 32'h1388);
    acc(1'b1, `STC_OFS_MASK, 32'h7);
    acc(1'b1, `STC_OFS_CTRL, 32'h3);
    acc(1'b1, `STC_OFS_DIV, 32'h5);
    wait_end();
    rdchk(`STC_OFS_STAT, 32'h1);
    rdchk(`STC_OFS_EXC, 32'h20);
    rdchk(`STC_OFS_CUR, 32'h1);
    rdchk(`STC_OFS_DIV, 32'h0);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `STC_OFS_STAT, 32'h7);
    acc(1'b1, `STC_OFS_EXC, 32'h20);
    @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // Resume into a failing interval with the interrupt masked
    acc(1'b1, `STC_OFS_MASK, 32'h0);
    fault <= 1'b1;
    acc(1'b1, `STC_OFS_CTRL, 32'h1);
    wait_end();
    rdchk(`STC_OFS_STAT, 32'h2);
    rdchk(`STC_OFS_FAIL, 32'h1);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, `STC_OFS_MASK, 32'h7);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, `STC_OFS_STAT, 32'h7);
    fault <= 1'b0;
    // Timeout long before the interval ends
    acc(1'b1, `STC_OFS_TMO, 32'h64);
    acc(1'b1, `STC_OFS_CTRL, 32'h3);
    @(negedge clk_sys);
    chk({31'h0, core_isolate}, 32'h1);
    wait_end();
    rdchk(`STC_OFS_STAT, 32'h4);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(`STC_OFS_TMO, 32'h0010_0000);
    conclude();
  end
endmodule : tb

bind stc_top stc_top_chk stc_top_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .waitrequest(waitrequest), .test_pattern(test_pattern),
  .core_isolate(core_isolate), .proc_clk_en(proc_clk_en),
  .delayed_proc_clk_en(delayed_proc_clk_en), .cpu_reset(cpu_reset));
